// ==== dbg_consts.vh ====
/*
 Constants for the breakpoint and trace debug block.
 Assumes a 100 MHz system clock; included by the debug block only.
*/
`ifndef DBG_CONSTS_VH
`define DBG_CONSTS_VH
`define REG_ADDR_CMP     4'h0
`define REG_ADDR_MASK    4'h1
`define REG_DATA_CMP     4'h2
`define REG_DATA_MASK    4'h3
`define REG_PC_CMP0      4'h4
`define REG_PC_CMP1      4'h5
`define REG_PC_CMP2      4'h6
`define REG_PC_CMP3      4'h7
`define REG_PC_MASK      4'h8
`define REG_TRIG_CTRL    4'h9
`define REG_COUNT        4'ha
`define TRIG_CTRL_RESET  32'h0000_0000
`define TC_EN_ADDR       0
`define TC_EN_DATA       1
`define TC_EN_PC         2
`define TC_TWO_LEVEL     3
`define TC_L2_EN_ADDR    4
`define TC_L2_EN_DATA    5
`define TC_L2_EN_PC      6
`define TC_ACT_IRQ       7
`define SER_FRAME_BITS   6'd40
`define SER_CMD_WRITE    1'b1
`define PST_HALTED       4'hf
`define PST_RUN          4'h0
`define PST_BRANCH       4'h5
`define PST_DEBUG_IRQ    4'hc
`define FIFO_DEPTH       16
`define FIFO_AW          4
`endif

// ==== dbg_fifo.v ====
/*
 Synchronous FIFO, flip-flop storage, valid/ready on both sides.
 Assumes one clock and a synchronous-released active-low reset.
*/
`timescale 1ns/100ps
module dbg_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_sys,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;
    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ==== breakpoint_trace_debug.v ====
/*
 Breakpoint comparators, trigger sequencer, serial register channel and
 real-time trace port. Assumes the core presents address, data and PC
 with a valid strobe each cycle, and the debugger clocks the serial link.
*/
// Operation
// - Nine 32-bit breakpoint registers
// - Registers reachable serially and by supervisor core
// - Address, data, PC match; one or two levels
// - Trigger halts core or raises debug interrupt
// - Critical interrupts still serviced during debug interrupt
// - Drive status, trace data, trace clock
// - All-status output is AND of status
// - Status reads 1111 while halted
// - Serial channel and all-status always present
`timescale 1ns/100ps
`include "dbg_consts.vh"
module breakpoint_trace_debug (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        debug_serial_clock,
    input  wire        debug_serial_in,
    output reg         debug_serial_out,
    input  wire        sup_wr,
    input  wire        sup_rd,
    input  wire        sup_supervisor,
    input  wire [3:0]  sup_index,
    input  wire [31:0] sup_wdata,
    output reg  [31:0] sup_rdata,
    input  wire        cpu_valid,
    input  wire [31:0] cpu_addr,
    input  wire [31:0] cpu_data,
    input  wire [31:0] cpu_pc,
    input  wire        cpu_branch,
    input  wire        cpu_resume,
    input  wire        critical_irq,
    output reg         halt_req,
    output reg         debug_irq,
    output reg         critical_irq_allow,
    output reg  [3:0]  processor_status_bus,
    output reg  [3:0]  trace_data_bus,
    output reg         trace_clock_out,
    output reg         all_status_high,
    output reg         fifo_overflow
);
    reg [1:0]  rst_sync;
    wire       rst_i;
    reg [31:0] bp_reg [0:8];
    reg [31:0] trig_ctrl;
    reg        level1_armed;
    reg        halted;
    reg        in_debug_irq;
    reg [2:0]  sclk_sync;
    reg [1:0]  sdi_sync;
    reg [39:0] ser_shift;
    reg [5:0]  ser_count;
    reg        ser_wr;
    reg [3:0]  ser_index;
    reg [31:0] ser_wdata;
    reg [31:0] fifo_in;
    reg        fifo_in_valid;
    wire       fifo_in_ready;
    wire [31:0] fifo_out;
    wire       fifo_out_valid;
    reg        fifo_out_ready;
    reg [31:0] trace_word;
    reg [2:0]  nib_count;
    reg        trace_busy;
    wire       sclk_rise;
    wire       addr_hit;
    wire       data_hit;
    wire       pc_hit;
    wire       l1_fire;
    wire       l2_fire;
    wire       fire;
    integer    i;

    function match;
        input [31:0] value;
        input [31:0] cmp;
        input [31:0] mask;
        begin
            match = ((value ^ cmp) & ~mask) == 32'h0000_0000;
        end
    endfunction

    function [31:0] reg_read;
        input [3:0] idx;
        begin
            if (idx <= `REG_PC_MASK) begin
                reg_read = bp_reg[idx];
            end else if (idx == `REG_TRIG_CTRL) begin
                reg_read = trig_ctrl;
            end else if (idx == `REG_COUNT) begin
                reg_read = {28'h0000_000, 2'b00, halted, level1_armed};
            end else begin
                reg_read = 32'h0000_0000;
            end
        end
    endfunction

    function level_hit;
        input       en_a;
        input       en_d;
        input       en_p;
        input       ha;
        input       hd;
        input       hp;
        begin
            level_hit = (en_a | en_d | en_p) & (~en_a | ha) & (~en_d | hd) & (~en_p | hp);
        end
    endfunction

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_i = rst_sync[1];

    // Link pins cross into clk_sys; the serial clock is oversampled for edges
    always @(posedge clk_sys or negedge rst_i) begin
        if (!rst_i) begin
            sclk_sync <= 3'b000;
            sdi_sync  <= 2'b00;
        end else begin
            sclk_sync <= {sclk_sync[1:0], debug_serial_clock};
            sdi_sync  <= {sdi_sync[0], debug_serial_in};
        end
    end
    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];

    assign addr_hit = match(cpu_addr, bp_reg[`REG_ADDR_CMP], bp_reg[`REG_ADDR_MASK]);
    assign data_hit = match(cpu_data, bp_reg[`REG_DATA_CMP], bp_reg[`REG_DATA_MASK]);
    assign pc_hit   = match(cpu_pc, bp_reg[`REG_PC_CMP0], bp_reg[`REG_PC_MASK])
                    | match(cpu_pc, bp_reg[`REG_PC_CMP1], bp_reg[`REG_PC_MASK])
                    | match(cpu_pc, bp_reg[`REG_PC_CMP2], bp_reg[`REG_PC_MASK])
                    | match(cpu_pc, bp_reg[`REG_PC_CMP3], bp_reg[`REG_PC_MASK]);
    assign l1_fire  = cpu_valid & level_hit(trig_ctrl[`TC_EN_ADDR], trig_ctrl[`TC_EN_DATA],
                      trig_ctrl[`TC_EN_PC], addr_hit, data_hit, pc_hit);
    assign l2_fire  = cpu_valid & level1_armed & level_hit(trig_ctrl[`TC_L2_EN_ADDR],
                      trig_ctrl[`TC_L2_EN_DATA], trig_ctrl[`TC_L2_EN_PC],
                      addr_hit, data_hit, pc_hit);
    assign fire     = trig_ctrl[`TC_TWO_LEVEL] ? l2_fire : l1_fire;

    // Serial frame: one write flag, four index bits, three unused bits, 32 data bits, MSB first
    always @(posedge clk_sys or negedge rst_i) begin
        if (!rst_i) begin
            ser_shift        <= 40'h00_0000_0000;
            ser_count        <= 6'd0;
            ser_wr           <= 1'b0;
            ser_index        <= 4'h0;
            ser_wdata        <= 32'h0000_0000;
            debug_serial_out <= 1'b0;
        end else begin
            ser_wr <= 1'b0;
            if (sclk_rise) begin
                if (ser_count == `SER_FRAME_BITS - 6'd1) begin
                    ser_count <= 6'd0;
                    if (ser_shift[38] == `SER_CMD_WRITE) begin
                        ser_wr <= 1'b1;
                    end
                    ser_index <= ser_shift[37:34];
                    ser_wdata <= {ser_shift[30:0], sdi_sync[1]};
                    ser_shift <= {reg_read(ser_shift[37:34]), 8'h00};
                end else begin
                    ser_count <= ser_count + 6'd1;
                    ser_shift <= {ser_shift[38:0], sdi_sync[1]};
                end
                debug_serial_out <= ser_shift[39];
            end
        end
    end

    // Register file; serial write wins over a same-cycle core write
    always @(posedge clk_sys or negedge rst_i) begin
        if (!rst_i) begin
            for (i = 0; i < 9; i = i + 1) begin
                bp_reg[i] <= 32'h0000_0000;
            end
            trig_ctrl <= `TRIG_CTRL_RESET;
        end else if (ser_wr) begin
            if (ser_index <= `REG_PC_MASK) begin
                bp_reg[ser_index] <= ser_wdata;
            end else if (ser_index == `REG_TRIG_CTRL) begin
                trig_ctrl <= ser_wdata;
            end
        end else if (sup_wr && sup_supervisor) begin
            if (sup_index <= `REG_PC_MASK) begin
                bp_reg[sup_index] <= sup_wdata;
            end else if (sup_index == `REG_TRIG_CTRL) begin
                trig_ctrl <= sup_wdata;
            end
        end
    end

    // Trigger sequencer and actions
    always @(posedge clk_sys or negedge rst_i) begin
        if (!rst_i) begin
            sup_rdata          <= 32'h0000_0000;
            level1_armed       <= 1'b0;
            halted             <= 1'b0;
            in_debug_irq       <= 1'b0;
            halt_req           <= 1'b0;
            debug_irq          <= 1'b0;
            critical_irq_allow <= 1'b0;
        end else begin
            // Read on the clock: a function's inner reads never wake a comb process
            if (sup_rd && sup_supervisor) begin
                sup_rdata <= reg_read(sup_index);
            end else begin
                sup_rdata <= 32'h0000_0000;
            end
            debug_irq <= 1'b0;
            if (trig_ctrl[`TC_TWO_LEVEL] && l1_fire && !level1_armed) begin
                level1_armed <= 1'b1;
            end else if (fire || !trig_ctrl[`TC_TWO_LEVEL]) begin
                level1_armed <= 1'b0;
            end
            if (fire && !halted && !in_debug_irq) begin
                if (trig_ctrl[`TC_ACT_IRQ]) begin
                    debug_irq    <= 1'b1;
                    in_debug_irq <= 1'b1;
                end else begin
                    halted <= 1'b1;
                end
            end else if (cpu_resume) begin
                halted       <= 1'b0;
                in_debug_irq <= 1'b0;
            end
            halt_req           <= halted;
            critical_irq_allow <= in_debug_irq & critical_irq;
        end
    end

    // Trace: branch targets queue in the FIFO and leave a nibble per cycle
    always @* begin
        fifo_in       = cpu_pc;
        fifo_in_valid = cpu_valid & cpu_branch;
        fifo_out_ready = ~trace_busy;
    end

    dbg_fifo #(
        .WIDTH (32),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_i),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready)
    );

    always @(posedge clk_sys or negedge rst_i) begin
        if (!rst_i) begin
            trace_word           <= 32'h0000_0000;
            nib_count            <= 3'd0;
            trace_busy           <= 1'b0;
            processor_status_bus <= `PST_HALTED;
            trace_data_bus       <= 4'h0;
            trace_clock_out      <= 1'b0;
            all_status_high      <= 1'b1;
            fifo_overflow        <= 1'b0;
        end else begin
            trace_clock_out <= ~trace_clock_out;
            if (fifo_in_valid && !fifo_in_ready) begin
                fifo_overflow <= 1'b1;
            end else if (sup_wr && sup_supervisor && sup_index == `REG_COUNT) begin
                fifo_overflow <= 1'b0;
            end
            if (trace_busy) begin
                trace_data_bus <= trace_word[3:0];
                trace_word     <= {4'h0, trace_word[31:4]};
                nib_count      <= nib_count + 3'd1;
                if (nib_count == 3'd7) begin
                    trace_busy <= 1'b0;
                end
            end else if (fifo_out_valid) begin
                trace_word <= fifo_out;
                trace_busy <= 1'b1;
                nib_count  <= 3'd0;
            end
            if (halted) begin
                processor_status_bus <= `PST_HALTED;
                all_status_high      <= 1'b1;
            end else if (in_debug_irq) begin
                processor_status_bus <= `PST_DEBUG_IRQ;
                all_status_high      <= 1'b0;
            end else if (fifo_out_valid && !trace_busy) begin
                processor_status_bus <= `PST_BRANCH;
                all_status_high      <= 1'b0;
            end else begin
                processor_status_bus <= `PST_RUN;
                all_status_high      <= 1'b0;
            end
        end
    end
endmodule

// ==== breakpoint_trace_debug_assertions.sv ====
/*
 Checker for the breakpoint and trace debug block, watching top ports only.
 Assumes rst_n is the raw asynchronous reset seen at the block's pins.
*/
`timescale 1ns/100ps
module breakpoint_trace_debug_assertions (
    input wire        clk_sys,
    input wire        rst_n,
    input wire        sup_rd,
    input wire [31:0] sup_rdata,
    input wire        cpu_resume,
    input wire        critical_irq,
    input wire        halt_req,
    input wire        debug_irq,
    input wire        critical_irq_allow,
    input wire [3:0]  processor_status_bus,
    input wire        trace_clock_out,
    input wire        all_status_high
);
    // The block releases its own reset two edges late, so wait three
    reg  [2:0] up;
    wire       live;
    assign live = up[2];
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            up <= 3'h0;
        else
            up <= {up[1:0], 1'b1};
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!live);
    chk_all_status_and: assert property (
        all_status_high == &processor_status_bus) else $error("all-status not AND of status");
    chk_halt_shows_f: assert property (
        $rose(halt_req) |-> processor_status_bus == 4'hf) else $error("halt without status f");
    chk_trace_clk_tog: assert property (
        trace_clock_out != $past(trace_clock_out)) else $error("trace clock stalled");
    chk_irq_one_pulse: assert property (
        debug_irq |=> !debug_irq) else $error("debug interrupt longer than a cycle");
    chk_crit_has_cause: assert property (
        critical_irq_allow |-> $past(critical_irq)) else $error("critical allow without request");
    chk_rdata_idle_zero: assert property (
        !$past(sup_rd) |-> sup_rdata == 32'h0) else $error("read data not zero when idle");
    chk_resume_ends: assert property (
        halt_req && cpu_resume |-> ##[1:4] !halt_req) else $error("halt not left on resume");
    chk_branch_then_data: assert property (
        processor_status_bus == 4'h5 |=> processor_status_bus != 4'h5)
        else $error("branch marker held");
    cov_halt: cover property ($rose(halt_req));
    cov_irq: cover property (debug_irq);
    cov_branch: cover property (processor_status_bus == 4'h5);
endmodule
bind breakpoint_trace_debug breakpoint_trace_debug_assertions u_breakpoint_trace_debug_assertions (
    .clk_sys(clk_sys), .rst_n(rst_n), .sup_rd(sup_rd), .sup_rdata(sup_rdata),
    .cpu_resume(cpu_resume), .critical_irq(critical_irq), .halt_req(halt_req),
    .debug_irq(debug_irq), .critical_irq_allow(critical_irq_allow),
    .processor_status_bus(processor_status_bus), .trace_clock_out(trace_clock_out),
    .all_status_high(all_status_high));

// ==== debug_probe.sv ====
/*
 Behavioural external debugger on the three-wire serial channel.
 Assumes the block samples the serial clock with its own faster clock.
*/
`timescale 1ns/100ps
module debug_probe #(
    parameter HALF = 80
) (
    output reg  debug_serial_clock,
    output reg  debug_serial_in,
    input  wire debug_serial_out
);
    initial begin
        debug_serial_clock = 1'b0;
        debug_serial_in = 1'b0;
    end
    // Clock stands low between frames; a released data line shows the inverse
    task frame(input logic wr, input logic [3:0] idx, input logic [31:0] d,
               output logic [31:0] q);
        logic [39:0] sh;
        int          i;
        begin
            sh = {wr, idx, 3'b000, d};
            q = 32'h0;
            for (i = 39; i >= 0; i--) begin
                debug_serial_in = sh[i];
                #HALF debug_serial_clock = 1'b1;
                #HALF debug_serial_clock = 1'b0;
                if (i >= 8)
                    q = {q[30:0], debug_serial_out};
            end
            debug_serial_in = ~sh[0];
        end
    endtask
endmodule

// ==== breakpoint_trace_debug_bench.sv ====
/*
 Self-checking bench: serial and core register paths, triggers, trace port.
 Assumes the debug_probe model drives the serial channel.
*/
`timescale 1ns/100ps
module breakpoint_trace_debug_bench;
    reg         clk_sys, rst_n, sup_wr, sup_rd, sup_supervisor, cpu_valid;
    reg         cpu_branch, cpu_resume, critical_irq;
    reg  [3:0]  sup_index;
    reg  [31:0] sup_wdata, cpu_addr, cpu_data, cpu_pc;
    wire        debug_serial_clock, debug_serial_in, debug_serial_out, halt_req;
    wire        debug_irq, critical_irq_allow, trace_clock_out, all_status_high;
    wire        fifo_overflow;
    wire [31:0] sup_rdata;
    wire [3:0]  processor_status_bus, trace_data_bus;
    int         mismatches = 0;
    int         tests_run = 0;
    int         i;
    logic [31:0] q;
    breakpoint_trace_debug u_breakpoint_trace_debug (
        .clk_sys(clk_sys), .rst_n(rst_n), .debug_serial_clock(debug_serial_clock),
        .debug_serial_in(debug_serial_in), .debug_serial_out(debug_serial_out),
        .sup_wr(sup_wr), .sup_rd(sup_rd), .sup_supervisor(sup_supervisor),
        .sup_index(sup_index), .sup_wdata(sup_wdata), .sup_rdata(sup_rdata),
        .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_pc(cpu_pc),
        .cpu_branch(cpu_branch), .cpu_resume(cpu_resume), .critical_irq(critical_irq),
        .halt_req(halt_req), .debug_irq(debug_irq), .critical_irq_allow(critical_irq_allow),
        .processor_status_bus(processor_status_bus), .trace_data_bus(trace_data_bus),
        .trace_clock_out(trace_clock_out), .all_status_high(all_status_high),
        .fifo_overflow(fifo_overflow));
    debug_probe u_debug_probe (.debug_serial_clock(debug_serial_clock),
        .debug_serial_in(debug_serial_in), .debug_serial_out(debug_serial_out));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task stop_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        begin
            tests_run++;
            if (got !== exp) begin
                mismatches++;
                $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wait_for(input int which, input logic v);
        int n;
        begin
            for (n = 0; n < 60; n++) begin
                if ((which == 0 ? halt_req : which == 1 ? debug_irq :
                     processor_status_bus == 4'h5) === v)
                    break;
                @(negedge clk_sys);
            end
            if (n == 60) begin
                mismatches++;
                $display("CHECK FAILED wait %0d expected %b seen timeout", which, v);
                stop_test;
            end
        end
    endtask
    task core_wr(input logic sup, input logic [3:0] idx, input logic [31:0] d);
        begin
            @(negedge clk_sys);
            {sup_wr, sup_supervisor, sup_index, sup_wdata} = {1'b1, sup, idx, d};
            @(negedge clk_sys);
            {sup_wr, sup_supervisor} = 2'b01;
        end
    endtask
    task core_rd(input logic [3:0] idx, output logic [31:0] d);
        begin
            @(negedge clk_sys);
            {sup_rd, sup_index} = {1'b1, idx};
            @(negedge clk_sys);
            d = sup_rdata;
            sup_rd = 1'b0;
        end
    endtask
    task cpu_op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] p,
                input logic br);
        begin
            @(negedge clk_sys);
            {cpu_valid, cpu_branch, cpu_addr, cpu_data, cpu_pc} = {1'b1, br, a, d, p};
            @(negedge clk_sys);
            {cpu_valid, cpu_branch} = 2'b00;
        end
    endtask
    task resume;
        begin
            @(negedge clk_sys);
            cpu_resume = 1'b1;
            @(negedge clk_sys);
            cpu_resume = 1'b0;
            wait_for(0, 1'b0);
        end
    endtask
    task t_regs;
        begin
            core_wr(1'b1, 4'h7, 32'h8000_0001);
            core_wr(1'b1, 4'h8, 32'h0);
            core_wr(1'b0, 4'h8, 32'hffff_ffff);
            core_rd(4'h8, q);
            check("user write ignored", 32'h0, q);
            u_debug_probe.frame(1'b1, 4'h0, 32'ha5c3_0f1e, q);
            u_debug_probe.frame(1'b0, 4'h0, 32'h0, q);
            u_debug_probe.frame(1'b0, 4'h7, 32'h0, q);
            check("serial addr cmp", 32'ha5c3_0f1e, q);
            u_debug_probe.frame(1'b0, 4'hb, 32'h0, q);
            check("serial pc cmp3", 32'h8000_0001, q);
            u_debug_probe.frame(1'b0, 4'h0, 32'h0, q);
            check("unmapped read", 32'h0, q);
            core_rd(4'h0, q);
            check("core addr cmp", 32'ha5c3_0f1e, q);
            $display("t_regs done");
        end
    endtask
    task t_halt;
        begin
            core_wr(1'b1, 4'h0, 32'h100);
            core_wr(1'b1, 4'h1, 32'hf);
            core_wr(1'b1, 4'h9, 32'h1);
            cpu_op(32'h10b, 32'h0, 32'hff0, 1'b0);
            wait_for(0, 1'b1);
            check("halt status", 4'hf, processor_status_bus);
            check("all high", 1'b1, all_status_high);
            resume;
            core_wr(1'b1, 4'h1, 32'h0);
            core_wr(1'b1, 4'h2, 32'hdead_beef);
            core_wr(1'b1, 4'h3, 32'h0);
            core_wr(1'b1, 4'h9, 32'h29);
            cpu_op(32'h0, 32'hdead_beef, 32'hff0, 1'b0);
            cpu_op(32'h100, 32'h0, 32'hff0, 1'b0);
            core_rd(4'ha, q);
            check("level 2 armed", 2'b01, q[1:0]);
            check("no early halt", 1'b0, halt_req);
            cpu_op(32'h0, 32'hdead_beef, 32'hff0, 1'b0);
            wait_for(0, 1'b1);
            resume;
            $display("t_halt done");
        end
    endtask
    task t_irq;
        begin
            core_wr(1'b1, 4'h6, 32'h2000);
            core_wr(1'b1, 4'h9, 32'h84);
            cpu_op(32'h0, 32'h0, 32'h2000, 1'b0);
            wait_for(1, 1'b1);
            critical_irq = 1'b1;
            repeat (3) @(negedge clk_sys);
            check("critical served", 1'b1, critical_irq_allow);
            check("irq no halt", 1'b0, halt_req);
            check("irq status", 4'hc, processor_status_bus);
            critical_irq = 1'b0;
            resume;
            critical_irq = 1'b1;
            repeat (3) @(negedge clk_sys);
            check("critical outside", 1'b0, critical_irq_allow);
            critical_irq = 1'b0;
            core_wr(1'b1, 4'h9, 32'h0);
            $display("t_irq done");
        end
    endtask
    task t_trace;
        begin
            cpu_op(32'h0, 32'h0, 32'h1234_5678, 1'b1);
            wait_for(2, 1'b1);
            for (i = 0; i < 8; i++) begin
                @(negedge clk_sys);
                check("trace nibble", 4'h8 - i, trace_data_bus);
            end
            // Back-to-back branches outrun the 9-cycle drain and must overflow
            @(negedge clk_sys);
            {cpu_valid, cpu_branch} = 2'b11;
            for (i = 0; i < 24; i++) begin
                cpu_pc = 32'h4000 + i;
                @(negedge clk_sys);
            end
            {cpu_valid, cpu_branch} = 2'b00;
            check("overflow", 1'b1, fifo_overflow);
            core_wr(1'b1, 4'ha, 32'h0);
            check("overflow clear", 1'b0, fifo_overflow);
            repeat (250) @(negedge clk_sys);
            $display("t_trace done");
        end
    endtask
    initial begin
        {rst_n, sup_wr, sup_rd, sup_supervisor, cpu_valid, cpu_branch} = 6'h0;
        {cpu_resume, critical_irq, sup_index, sup_wdata, cpu_addr, cpu_data} = 0;
        cpu_pc = 32'hff0;
        repeat (6) @(negedge clk_sys);
        check("reset status", 4'hf, processor_status_bus);
        check("reset all high", 1'b1, all_status_high);
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_regs;
        t_halt;
        t_irq;
        t_trace;
        stop_test;
    end
endmodule
